// file: bench/data_memory_addressing_status_tb_top.sv
// self-checking bench for the register core
`timescale 1ns/100ps
module data_memory_addressing_status_tb_top;
   import dmas_pkg::*;
   typedef struct {dmas_alu_type op; logic [7:0] a, b, acc; logic [3:0] pre, en, fl;} dmas_row_type;
   logic clk_sys = 0, rst_n = 0, soft_reset = 0, wake_timeout_reset = 0;
   logic mem_rd = 0, mem_wr = 0, alu_go = 0, table_go = 0, alu_src_mem = 0, alu_to_mem = 0;
   logic halt_exec = 0, watchdog_clear_instruction = 0, watchdog_timeout = 0;
   logic [7:0] mem_addr = 0, mem_wdata = 0, alu_imm = 0, mem_rdata, accumulator, cpu_flags;
   logic [3:0] flag_wr_en = 0;
   dmas_alu_type alu_op = DMAS_ALU_PASS;
   logic [15:0] table_data, table_addr;
   logic pc_load, dummy_cycle;
   logic [10:0] pc_target, pc_now;
   int error_cnt = 0, check_count = 0;
   dmas_row_type rows [11] = '{
      '{DMAS_ALU_ADD, 8'h0F, 8'h01, 8'h10, 4'h0, 4'hF, 4'h2},
      '{DMAS_ALU_ADD, 8'h80, 8'h80, 8'h00, 4'h0, 4'hF, 4'hD},
      '{DMAS_ALU_ADD, 8'h7F, 8'h01, 8'h80, 4'h0, 4'hF, 4'hA},
      '{DMAS_ALU_SUB, 8'h05, 8'h05, 8'h00, 4'h0, 4'hF, 4'h7},
      '{DMAS_ALU_SUB, 8'h00, 8'h01, 8'hFF, 4'h0, 4'hF, 4'h0},
      '{DMAS_ALU_AND, 8'hF0, 8'h0F, 8'h00, 4'h0, 4'h4, 4'h4},
      '{DMAS_ALU_OR,  8'h12, 8'h21, 8'h33, 4'h4, 4'h4, 4'h0},
      '{DMAS_ALU_XOR, 8'hAA, 8'hAA, 8'h00, 4'h0, 4'h4, 4'h4},
      '{DMAS_ALU_RLC, 8'h81, 8'h81, 8'h02, 4'h0, 4'h1, 4'h1},
      '{DMAS_ALU_RRC, 8'h01, 8'h01, 8'h80, 4'h1, 4'h1, 4'h1},
      '{DMAS_ALU_ADD, 8'h01, 8'h01, 8'h02, 4'hF, 4'h0, 4'hF}};
   dmas_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .soft_reset(soft_reset),
      .wake_timeout_reset(wake_timeout_reset), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .alu_go(alu_go), .alu_op(alu_op),
      .alu_src_mem(alu_src_mem), .alu_imm(alu_imm), .alu_to_mem(alu_to_mem), .flag_wr_en(flag_wr_en),
      .halt_exec(halt_exec), .watchdog_clear_instruction(watchdog_clear_instruction),
      .watchdog_timeout(watchdog_timeout), .table_go(table_go), .table_data(table_data),
      .table_addr(table_addr), .pc_load(pc_load), .pc_target(pc_target), .pc_now(pc_now),
      .dummy_cycle(dummy_cycle), .accumulator(accumulator), .cpu_flags(cpu_flags));
   dmas_prog_model prog_u (.clk_sys(clk_sys), .rst_n(rst_n), .table_addr(table_addr),
      .table_data(table_data), .pc_load(pc_load), .pc_target(pc_target), .pc_now(pc_now));
   always #20 clk_sys = ~clk_sys;
   task automatic chk(input string name, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   // strobes last one cycle, then one idle cycle
   task automatic op(input logic r, w, g, t, input logic [7:0] a, d);
      {mem_rd, mem_wr, alu_go, table_go, mem_addr, mem_wdata} = {r, w, g, t, a, d};
      @(posedge clk_sys); #1;
      {mem_rd, mem_wr, alu_go, table_go} = 4'h0;
      @(posedge clk_sys); #1;
   endtask
   task automatic ev(input logic [4:0] v);
      {soft_reset, wake_timeout_reset, halt_exec, watchdog_clear_instruction, watchdog_timeout} = v;
      @(posedge clk_sys); #1;
      {soft_reset, wake_timeout_reset, halt_exec, watchdog_clear_instruction, watchdog_timeout} = 5'h00;
      @(posedge clk_sys); #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      op(1'b0, 1'b1, 1'b0, 1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      op(1'b1, 1'b0, 1'b0, 1'b0, a, 8'h00);
      chk("rdata", {8'h00, mem_rdata}, {8'h00, exp});
   endtask
   task automatic alu(input dmas_alu_type o, input logic [7:0] b, input logic [3:0] e);
      {alu_op, alu_imm, flag_wr_en} = {o, b, e};
      op(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #(40 * 4000);
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      #1;
      rst_n = 1;
      chk("flags", {8'h00, cpu_flags}, 16'h0000);
      rd(ADDR_BANK_SELECT, 8'h00);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(ADDR_CPU_FLAGS, {4'hF, rows[i].pre});
         alu(DMAS_ALU_PASS, rows[i].a, 4'h0);
         alu(rows[i].op, rows[i].b, rows[i].en);
         chk("acc", {8'h00, accumulator}, {8'h00, rows[i].acc});
         chk("flags", {8'h00, cpu_flags}, {12'h000, rows[i].fl});
      end
      $display("test alu done");
      wr(ADDR_CPU_FLAGS, 8'h00);
      ev(5'h04);
      chk("flags", {8'h00, cpu_flags}, 16'h0010);
      ev(5'h01);
      chk("flags", {8'h00, cpu_flags}, 16'h0030);
      wr(ADDR_CPU_FLAGS, 8'hC5);
      chk("flags", {8'h00, cpu_flags}, 16'h0035);
      ev(5'h02);
      chk("flags", {8'h00, cpu_flags}, 16'h0005);
      ev(5'h01);
      ev(5'h04);
      chk("flags", {8'h00, cpu_flags}, 16'h0015);
      ev(5'h07);
      chk("flags", {8'h00, cpu_flags}, 16'h0035);
      $display("test flags done");
      wr(ADDR_BANK_SELECT, 8'h01);
      ev(5'h18);
      rd(ADDR_BANK_SELECT, 8'h01);
      ev(5'h10);
      rd(ADDR_BANK_SELECT, 8'h00);
      wr(ADDR_POINTER_SECOND, 8'h90);
      wr(ADDR_BANK_SELECT, 8'h01);
      wr(ADDR_INDIRECT_SECOND, 8'h5A);
      wr(ADDR_BANK_SELECT, 8'h00);
      wr(ADDR_INDIRECT_SECOND, 8'hA5);
      wr(ADDR_BANK_SELECT, 8'hFF);
      rd(ADDR_BANK_SELECT, 8'h01);
      rd(8'h90, 8'hA5);
      rd(ADDR_INDIRECT_SECOND, 8'h5A);
      wr(ADDR_POINTER_FIRST, 8'h90);
      rd(ADDR_INDIRECT_FIRST, 8'hA5);
      rd(ADDR_POINTER_SECOND, 8'h90);
      wr(ADDR_POINTER_SECOND, ADDR_ACCUMULATOR);
      rd(ADDR_INDIRECT_SECOND, 8'h02);
      wr(ADDR_POINTER_FIRST, ADDR_INDIRECT_FIRST);
      wr(ADDR_INDIRECT_FIRST, 8'h77);
      rd(ADDR_INDIRECT_FIRST, 8'h00);
      rd(ADDR_POINTER_FIRST, 8'h00);
      wr(ADDR_BANK_SELECT, 8'hFE);
      rd(ADDR_BANK_SELECT, 8'h00);
      $display("test banks done");
      wr(ADDR_POINTER_FIRST, 8'h90);
      alu_src_mem = 1'b1;
      alu(DMAS_ALU_PASS, 8'h00, 4'h0);
      chk("acc", {8'h00, accumulator}, 16'h00A5);
      alu_to_mem = 1'b1;
      alu(DMAS_ALU_ADD, 8'h00, 4'h0);
      {alu_src_mem, alu_to_mem} = 2'b00;
      chk("acc", {8'h00, accumulator}, 16'h00A5);
      rd(8'h90, 8'h4A);
      $display("test alu memory done");
      {mem_wr, mem_addr, mem_wdata} = {1'b1, ADDR_PC_LOW, 8'h34};
      @(posedge clk_sys); #1;
      mem_wr = 1'b0;
      chk("jump", {3'h0, dummy_cycle, pc_load, pc_target}, 16'h1D34);
      @(posedge clk_sys); #1;
      chk("pc_load", {14'h0000, dummy_cycle, pc_load}, 16'h0000);
      wr(ADDR_TABLE_LOW, 8'h12);
      wr(ADDR_TABLE_PTR_HIGH, 8'h03);
      op(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
      chk("taddr", table_addr, 16'h0312);
      chk("tlow", {8'h00, mem_rdata}, 16'h00A6);
      rd(ADDR_TABLE_HIGH_BYTE, 8'h48);
      $display("test jump and table done");
      wr(ADDR_BANK_SELECT, 8'h01);
      ev(5'h04);
      rst_n = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      rst_n = 1;
      chk("flags", {8'h00, cpu_flags}, 16'h0000);
      chk("acc", {8'h00, accumulator}, 16'h0000);
      rd(ADDR_BANK_SELECT, 8'h00);
      $display("test second reset done");
      complete_run();
   end
endmodule

// file: bench/dmas_core_chk.sv
// port assertions for the register core
`timescale 1ns/100ps
module dmas_core_chk
   import dmas_pkg::*;
#(
   parameter int PC_WIDTH = 11
)
(
   // clock and reset
   input wire logic                clk_sys,
   input wire logic                rst_n,
   // requests
   input wire logic                mem_wr,
   input wire logic [7:0]          mem_addr,
   input wire logic [7:0]          mem_wdata,
   input wire logic                alu_go,
   input wire logic [3:0]          flag_wr_en,
   input wire logic                halt_exec,
   input wire logic                watchdog_clear_instruction,
   input wire logic                watchdog_timeout,
   // results
   input wire logic                pc_load,
   input wire logic [PC_WIDTH-1:0] pc_target,
   input wire logic [PC_WIDTH-1:0] pc_now,
   input wire logic                dummy_cycle,
   input wire logic [7:0]          cpu_flags
);
   logic sys_ev;
   assign sys_ev = halt_exec || watchdog_clear_instruction || watchdog_timeout;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_FLAG_TOP: assert property (cpu_flags[7:6] == 2'b00)
      else $error("flag bits 7:6 set");
   AST_SLEEP_SET: assert property (halt_exec |=> cpu_flags[4])
      else $error("sleep flag not set");
   AST_SLEEP_CLR: assert property (watchdog_clear_instruction && !halt_exec |=> !cpu_flags[4])
      else $error("sleep flag not cleared");
   AST_EXP_SET: assert property (watchdog_timeout |=> cpu_flags[5])
      else $error("expired flag not set");
   AST_EXP_CLR: assert property ((halt_exec || watchdog_clear_instruction) && !watchdog_timeout |=> !cpu_flags[5])
      else $error("expired flag not cleared");
   AST_SYS_HOLD: assert property (!sys_ev |=> $stable(cpu_flags[5:4]))
      else $error("system flags changed");
   AST_PC_JUMP: assert property (mem_wr && mem_addr == ADDR_PC_LOW && !alu_go |=>
      pc_load && dummy_cycle && pc_target[7:0] == $past(mem_wdata))
      else $error("pc low write gave no jump");
   AST_PC_PAGE: assert property (pc_load |-> pc_target[PC_WIDTH-1:8] == pc_now[PC_WIDTH-1:8])
      else $error("jump left the page");
   AST_FLAG_WR: assert property (mem_wr && mem_addr == ADDR_CPU_FLAGS && !alu_go |=>
      cpu_flags[3:0] == $past(mem_wdata[3:0]))
      else $error("flag write lost");
   AST_FLAG_KEEP: assert property (alu_go && flag_wr_en == 4'h0 && mem_addr != ADDR_CPU_FLAGS |=>
      $stable(cpu_flags[3:0]))
      else $error("disabled flag changed");
endmodule
bind dmas_core dmas_core_chk #(.PC_WIDTH(PC_WIDTH)) chk_u (
   .clk_sys(clk_sys), .rst_n(rst_n), .mem_wr(mem_wr), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .alu_go(alu_go), .flag_wr_en(flag_wr_en), .halt_exec(halt_exec),
   .watchdog_clear_instruction(watchdog_clear_instruction), .watchdog_timeout(watchdog_timeout),
   .pc_load(pc_load), .pc_target(pc_target), .pc_now(pc_now), .dummy_cycle(dummy_cycle),
   .cpu_flags(cpu_flags));

// file: bench/dmas_prog_model.sv
// program memory and program counter model
`timescale 1ns/100ps
module dmas_prog_model #(
   parameter int                  PC_WIDTH = 11,
   parameter logic [PC_WIDTH-1:0] PC_START = 'h500
)
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // table fetch
   input  wire logic [15:0]         table_addr,
   output logic [15:0]              table_data,
   // program counter
   input  wire logic                pc_load,
   input  wire logic [PC_WIDTH-1:0] pc_target,
   output logic [PC_WIDTH-1:0]      pc_now
);
   // each byte a distinct function of the address
   assign table_data = {table_addr[7:0] ^ 8'h5A, table_addr[15:8] ^ 8'hA5};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_now <= PC_START;
      end else if (pc_load) begin
         pc_now <= pc_target;
      end
   end
endmodule

// file: logic/dmas_alu.sv
// 8-bit alu with carry, nibble carry, zero and overflow results
`timescale 1ns/100ps
module dmas_alu
   import dmas_pkg::*;
(
   // operands
   input  wire logic [7:0]   op_a,
   input  wire logic [7:0]   op_b,
   input  wire logic         carry_in,
   input  wire dmas_alu_type op_sel,
   // results
   output logic [7:0]        result,
   output logic              carry_out,
   output logic              nibble_out,
   output logic              zero_out,
   output logic              overflow_out
);
   logic [8:0] sum;
   logic [4:0] low;
   logic [7:0] lsum;
   always_comb begin
      sum          = 9'h000;
      low          = 5'h00;
      lsum         = 8'h00;
      result       = op_a;
      carry_out    = carry_in;
      nibble_out   = 1'b0;
      overflow_out = 1'b0;
      unique case (op_sel)
         DMAS_ALU_PASS: result = op_b;
         DMAS_ALU_ADD, DMAS_ALU_SUB: begin
            // subtraction is a plus ~b plus one; carry set means no borrow
            sum          = {1'b0, op_a} + {1'b0, (op_sel == DMAS_ALU_SUB) ? ~op_b : op_b}
                           + {8'h00, op_sel == DMAS_ALU_SUB}; // see RQ13
            low          = {1'b0, op_a[3:0]} + {1'b0, (op_sel == DMAS_ALU_SUB) ? ~op_b[3:0] : op_b[3:0]}
                           + {4'h0, op_sel == DMAS_ALU_SUB}; // see RQ14
            lsum         = {1'b0, op_a[6:0]} + {1'b0, (op_sel == DMAS_ALU_SUB) ? ~op_b[6:0] : op_b[6:0]}
                           + {7'h00, op_sel == DMAS_ALU_SUB};
            result       = sum[7:0];
            carry_out    = sum[8];
            nibble_out   = low[4];
            overflow_out = lsum[7] ^ sum[8]; // see RQ16
         end
         DMAS_ALU_AND: result = op_a & op_b;
         DMAS_ALU_OR:  result = op_a | op_b;
         DMAS_ALU_XOR: result = op_a ^ op_b;
         DMAS_ALU_RLC: begin
            result    = {op_a[6:0], carry_in};
            carry_out = op_a[7]; // see RQ13
         end
         DMAS_ALU_RRC: begin
            result    = {carry_in, op_a[7:1]};
            carry_out = op_a[0];
         end
      endcase
      zero_out = (result == 8'h00); // see RQ15
   end
endmodule

// file: logic/dmas_core.sv
// special function register core: indirect ports, banks, accumulator, pc low, table, flags
`timescale 1ns/100ps
// How it works
// RQ1 - indirect port accesses act on pointed location
// RQ2 - first pair bank 0, second uses bank
// RQ3 - pointer at indirect port: read zero, write ignored
// RQ4 - pointers are plain readable writable 8-bit registers
// RQ5 - direct accesses always go to bank 0
// RQ6 - bank_select bit 0 only, rest zero
// RQ7 - resets clear bank except sleep watchdog reset
// RQ8 - special registers same in every bank
// RQ9 - pc low write jumps in page, dummy cycle
// RQ10 - table read: high byte kept, low to destination
// RQ11 - alu results land in accumulator only; with alu_to_mem the code writes them to the addressed location instead
// RQ12 - flag writes spare sleep and expired flags
// RQ13 - carry from add, no borrow, rotates
// RQ14 - nibble carry from low nibble
// RQ15 - zero flag when result is zero
// RQ16 - overflow when carry in differs from out
// RQ17 - sleep flag: power-up/clear low, halt high
// RQ18 - expired flag: clear, halt low, timeout high
// RQ19 - flags never pushed on call or interrupt
// RQ20 - flag bit layout, bits 7 and 6 zero
// RQ21 - per-flag write enables from instruction core
module dmas_core
   import dmas_pkg::*;
#(
   parameter int PC_WIDTH = 11
)
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   // reset cause from the system, sampled only with soft_reset; rst_n clears the bank regardless
   input  wire logic                 soft_reset,
   input  wire logic                 wake_timeout_reset,
   // data memory access from instruction core
   input  wire logic                 mem_rd,
   input  wire logic                 mem_wr,
   input  wire logic [7:0]           mem_addr,
   input  wire logic [7:0]           mem_wdata,
   output logic [7:0]                mem_rdata,
   // alu request
   input  wire logic                 alu_go,
   input  wire dmas_alu_type         alu_op,
   input  wire logic                 alu_src_mem,
   input  wire logic [7:0]           alu_imm,
   input  wire logic                 alu_to_mem,
   input  wire logic [3:0]           flag_wr_en,
   // system events
   input  wire logic                 halt_exec,
   input  wire logic                 watchdog_clear_instruction,
   input  wire logic                 watchdog_timeout,
   // table read
   input  wire logic                 table_go,
   input  wire logic [15:0]          table_data,
   output logic [15:0]               table_addr,
   // program counter page jump
   output logic                      pc_load,
   output logic [PC_WIDTH-1:0]       pc_target,
   input  wire logic [PC_WIDTH-1:0]  pc_now,
   output logic                      dummy_cycle,
   // visible state
   output logic [7:0]                accumulator,
   output logic [7:0]                cpu_flags
);
   localparam int GP_DEPTH = 128;

   typedef struct packed {
      logic [7:0]          pointer_first;
      logic [7:0]          pointer_second;
      logic                bank_select_bit;
      logic [7:0]          accumulator;
      logic [7:0]          table_pointer_low;
      logic [7:0]          table_pointer_high;
      logic [7:0]          table_read_high_byte;
      logic                carry;
      logic                nibble_carry_flag;
      logic                zero;
      logic                signed_overflow_flag;
      logic                sleep_flag;
      logic                watchdog_expired_flag;
      logic [7:0]          mem_rdata;
      logic                pc_load;
      logic [PC_WIDTH-1:0] pc_target;
      logic                dummy_cycle;
      logic [15:0]         table_addr;
   } dmas_state_type;

   dmas_state_type state_reg;
   dmas_state_type state_next;
   logic [7:0]     gp_mem [0:2*GP_DEPTH-1];

   // effective address resolution
   logic       is_ind_first;
   logic       is_ind_second;
   logic [7:0] eff_addr;
   logic       eff_bank;
   logic       eff_null;
   logic       eff_gp;
   logic [7:0] sfr_rdata;
   logic [7:0] rd_value;
   logic [7:0] flags_view;
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic       alu_c;
   logic       alu_ac;
   logic       alu_z;
   logic       alu_ov;
   logic       wr_any;
   logic [7:0] wr_value;
   logic       gp_we;
   logic [7:0] gp_index;

   dmas_alu u_alu (
      .op_a         (state_reg.accumulator),
      .op_b         (alu_b),
      .carry_in     (state_reg.carry),
      .op_sel       (alu_op),
      .result       (alu_res),
      .carry_out    (alu_c),
      .nibble_out   (alu_ac),
      .zero_out     (alu_z),
      .overflow_out (alu_ov)
   );

   always_comb begin
      is_ind_first  = (mem_addr == ADDR_INDIRECT_FIRST);
      is_ind_second = (mem_addr == ADDR_INDIRECT_SECOND);
      eff_addr      = mem_addr;
      eff_bank      = 1'b0; // see RQ5
      if (is_ind_first) begin
         eff_addr = state_reg.pointer_first; // see RQ1
         eff_bank = 1'b0; // see RQ2
      end else if (is_ind_second) begin
         eff_addr = state_reg.pointer_second;
         eff_bank = state_reg.bank_select_bit; // see RQ2
      end
      // pointer naming an indirect port reaches nothing
      eff_null = (is_ind_first || is_ind_second)
                 && (eff_addr == ADDR_INDIRECT_FIRST || eff_addr == ADDR_INDIRECT_SECOND); // see RQ3
      eff_gp   = (eff_addr >= ADDR_GP_BASE);
      gp_index = {eff_bank, eff_addr[6:0]};
   end

   always_comb begin
      flags_view = {2'b00, state_reg.watchdog_expired_flag, state_reg.sleep_flag,
                    state_reg.signed_overflow_flag, state_reg.zero,
                    state_reg.nibble_carry_flag, state_reg.carry}; // see RQ20
      // special area decodes alike in every bank
      unique case (eff_addr) // see RQ8
         ADDR_POINTER_FIRST:   sfr_rdata = state_reg.pointer_first; // see RQ4
         ADDR_POINTER_SECOND:  sfr_rdata = state_reg.pointer_second;
         ADDR_BANK_SELECT:     sfr_rdata = {7'h00, state_reg.bank_select_bit}; // see RQ6
         ADDR_ACCUMULATOR:     sfr_rdata = state_reg.accumulator;
         ADDR_PC_LOW:          sfr_rdata = pc_now[7:0];
         ADDR_TABLE_LOW:       sfr_rdata = state_reg.table_pointer_low;
         ADDR_TABLE_HIGH_BYTE: sfr_rdata = state_reg.table_read_high_byte;
         ADDR_TABLE_PTR_HIGH:  sfr_rdata = state_reg.table_pointer_high;
         ADDR_CPU_FLAGS:       sfr_rdata = flags_view;
         default:              sfr_rdata = RESET_BYTE;
      endcase
      if (eff_null)
         rd_value = RESET_BYTE; // see RQ3
      else if (eff_gp)
         rd_value = gp_mem[gp_index];
      else
         rd_value = sfr_rdata;
      alu_b = alu_src_mem ? rd_value : alu_imm;
   end

   always_comb begin
      state_next             = state_reg;
      state_next.pc_load     = 1'b0;
      state_next.dummy_cycle = 1'b0;
      // alu results go to the accumulator or back to the read location
      wr_any   = mem_wr || (alu_go && alu_to_mem);
      wr_value = alu_go ? alu_res : mem_wdata;
      if (mem_rd)
         state_next.mem_rdata = rd_value;
      if (alu_go && !alu_to_mem)
         state_next.accumulator = alu_res; // see RQ11
      if (table_go) begin
         state_next.table_read_high_byte = table_data[15:8]; // see RQ10
         state_next.mem_rdata            = table_data[7:0];
      end
      state_next.table_addr = {state_next.table_pointer_high, state_next.table_pointer_low};
      gp_we = wr_any && !eff_null && eff_gp;
      if (wr_any && !eff_null && !eff_gp) begin
         unique case (eff_addr)
            ADDR_POINTER_FIRST:  state_next.pointer_first  = wr_value; // see RQ4
            ADDR_POINTER_SECOND: state_next.pointer_second = wr_value;
            ADDR_BANK_SELECT:    state_next.bank_select_bit = wr_value[0]; // see RQ6
            ADDR_ACCUMULATOR:    state_next.accumulator    = wr_value;
            ADDR_PC_LOW: begin
               state_next.pc_load     = 1'b1; // see RQ9
               state_next.pc_target   = {pc_now[PC_WIDTH-1:8], wr_value};
               state_next.dummy_cycle = 1'b1;
            end
            ADDR_TABLE_LOW:       state_next.table_pointer_low    = wr_value;
            ADDR_TABLE_HIGH_BYTE: state_next.table_read_high_byte = wr_value;
            ADDR_TABLE_PTR_HIGH:  state_next.table_pointer_high   = wr_value;
            ADDR_CPU_FLAGS: begin
               // system flags are read only here
               state_next.carry                = wr_value[FLAG_CARRY]; // see RQ12
               state_next.nibble_carry_flag    = wr_value[FLAG_NIBBLE];
               state_next.zero                 = wr_value[FLAG_ZERO];
               state_next.signed_overflow_flag = wr_value[FLAG_OVERFLOW];
            end
            default: ;
         endcase
         state_next.table_addr = {state_next.table_pointer_high, state_next.table_pointer_low};
      end
      // arithmetic flags follow the alu, each only when enabled
      if (alu_go) begin
         if (flag_wr_en[FLAG_CARRY])    state_next.carry                = alu_c; // see RQ21 see RQ13
         if (flag_wr_en[FLAG_NIBBLE])   state_next.nibble_carry_flag    = alu_ac; // see RQ14
         if (flag_wr_en[FLAG_ZERO])     state_next.zero                 = alu_z; // see RQ15
         if (flag_wr_en[FLAG_OVERFLOW]) state_next.signed_overflow_flag = alu_ov; // see RQ16
      end
      if (watchdog_clear_instruction) begin
         state_next.sleep_flag            = 1'b0; // see RQ17
         state_next.watchdog_expired_flag = 1'b0; // see RQ18
      end
      if (halt_exec) begin
         state_next.sleep_flag            = 1'b1;
         state_next.watchdog_expired_flag = 1'b0;
      end
      // a timeout in the same cycle as a clear still sets
      if (watchdog_timeout)
         state_next.watchdog_expired_flag = 1'b1; // see RQ18
      // warm reset: bank cleared unless it is a timeout out of sleep
      if (soft_reset && !wake_timeout_reset)
         state_next.bank_select_bit = RESET_BANK_BIT; // see RQ7
      // no push of the flags is offered to call or interrupt logic; see RQ19
   end

   always_ff @(posedge clk_sys) begin
      if (gp_we)
         gp_mem[gp_index] <= wr_value;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0; // see RQ7 see RQ17 see RQ18
      end else begin
         state_reg <= state_next;
      end
   end

   assign mem_rdata   = state_reg.mem_rdata;
   assign accumulator = state_reg.accumulator;
   assign cpu_flags   = {2'b00, state_reg.watchdog_expired_flag, state_reg.sleep_flag,
                         state_reg.signed_overflow_flag, state_reg.zero,
                         state_reg.nibble_carry_flag, state_reg.carry};
   assign table_addr  = state_reg.table_addr;
   assign pc_load     = state_reg.pc_load;
   assign pc_target   = state_reg.pc_target;
   assign dummy_cycle = state_reg.dummy_cycle;
endmodule

// file: logic/dmas_pkg.sv
// package for the data memory addressing and status register core
package dmas_pkg;
   // special function register addresses
   localparam logic [7:0] ADDR_INDIRECT_FIRST  = 8'h00;
   localparam logic [7:0] ADDR_POINTER_FIRST   = 8'h01;
   localparam logic [7:0] ADDR_INDIRECT_SECOND = 8'h02;
   localparam logic [7:0] ADDR_POINTER_SECOND  = 8'h03;
   localparam logic [7:0] ADDR_BANK_SELECT     = 8'h04;
   localparam logic [7:0] ADDR_ACCUMULATOR     = 8'h05;
   localparam logic [7:0] ADDR_PC_LOW          = 8'h06;
   localparam logic [7:0] ADDR_TABLE_LOW       = 8'h07;
   localparam logic [7:0] ADDR_TABLE_HIGH_BYTE = 8'h08;
   localparam logic [7:0] ADDR_TABLE_PTR_HIGH  = 8'h09;
   localparam logic [7:0] ADDR_CPU_FLAGS       = 8'h0A;
   // first general purpose address; below it lies the special area
   localparam logic [7:0] ADDR_GP_BASE         = 8'h80;
   // cpu_flags field positions
   localparam int FLAG_CARRY    = 0;
   localparam int FLAG_NIBBLE   = 1;
   localparam int FLAG_ZERO     = 2;
   localparam int FLAG_OVERFLOW = 3;
   localparam int FLAG_SLEEP    = 4;
   localparam int FLAG_EXPIRED  = 5;
   // reset values
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic       RESET_BANK_BIT  = 1'b0;
   localparam logic [5:0] RESET_FLAGS     = 6'h00;
   // alu operations
   typedef enum logic [2:0] {
      DMAS_ALU_PASS,
      DMAS_ALU_ADD,
      DMAS_ALU_SUB,
      DMAS_ALU_AND,
      DMAS_ALU_OR,
      DMAS_ALU_XOR,
      DMAS_ALU_RLC,
      DMAS_ALU_RRC
   } dmas_alu_type;
endpackage
